// file: gpdma_fifo.sv
`timescale 1ns/1ns
// ==========================================================================
// Small flip-flop buffer between source reads and destination writes.
module gpdma_fifo
  import gpdma_pkg::*;
#(
  parameter int W = 32,
  parameter int D = 4
)(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Buffer port.
  gpdma_fifo_if.store f
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic          do_push;
  logic          do_pop;

  // Pushes into a full buffer and pops from an empty one are dropped.
  assign do_push = f.push && !f.full;
  assign do_pop  = f.pop && !f.empty;
  assign f.full  = (cnt_reg == (AW+1)'(D));
  assign f.empty = (cnt_reg == '0);
  assign f.rdata = mem_reg[rp_reg];

  // Pointers wrap at the depth; a flush empties the buffer at once.
  always_ff @(posedge clk)
  begin
    if (!rst_n || f.flush)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (do_push)
      begin
        mem_reg[wp_reg] <= f.wdata;
        wp_reg <= (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (do_pop)
        rp_reg <= (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// file: gpdma_fifo_if.sv
`timescale 1ns/1ns
// ==========================================================================
// Channel buffer connection.
interface gpdma_fifo_if #(parameter int W = 32) ();
  logic         push;
  logic         pop;
  logic         flush;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic         full;
  logic         empty;

  modport store (input push, pop, flush, wdata, output rdata, full, empty);
  modport user  (output push, pop, flush, wdata, input rdata, full, empty);
endinterface

// file: gpdma_mem_model.sv
`timescale 1ns/1ns
// ====
// Bus memory; addresses with top nibble E answer with an error.
module gpdma_mem_model (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_n,
  // Wait state request.
  input wire logic        slow,
  // Bus slave port.
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  output logic     [31:0] hrdata,
  output logic            hready,
  output logic            hresp
);
  logic [31:0] mem [64];
  logic        dp, wr, wt;
  logic [31:0] a;
  logic [1:0]  sz;
  // Idle read lines show the inverse so stale data is never mistaken.
  assign hready = !(dp && wt);
  assign hresp = dp && hready && a[31:28]==4'hE;
  assign hrdata = dp ? mem[a[7:2]] : ~mem[a[7:2]];
  // Phase tracking and lane-wise writes; the bench preloads the array directly.
  always @(posedge clk)
    if (!rst_n)
      dp <= 1'b0;
    else if (!hready)
      wt <= 1'b0;
    else
    begin
      for (int i = 0; i < 4; i++)
        if (dp && wr && !hresp && (sz[1] || (sz[0] ? i/2==a[1] : i==a[1:0])))
          mem[a[7:2]][8*i+:8] <= hwdata[8*i+:8];
      dp <= htrans==2'h2;
      a <= haddr;
      wr <= hwrite;
      sz <= hsize[1:0];
      wt <= slow;
    end
endmodule

// file: gpdma_pkg.sv
// ==========================================================================
// Types shared by the controller.
package gpdma_pkg;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_RA   = 8'h02,
    S_RD   = 8'h04,
    S_WA   = 8'h08,
    S_WD   = 8'h10,
    S_CHK  = 8'h20,
    S_LA   = 8'h40,
    S_LD   = 8'h80
  } gpdma_state_t;

  typedef enum logic [1:0] {
    FLOW_M2M = 2'h0,
    FLOW_M2P = 2'h1,
    FLOW_P2M = 2'h2,
    FLOW_P2P = 2'h3
  } gpdma_flow_t;

endpackage

// file: gpdma_props.sv
`timescale 1ns/1ns
// ====
// Bus and register port checks.
module gpdma_props (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_n,
  // Watched ports.
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hresp
);
  // All checks share one clock.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata==32'h0)
    else $error("stray read data");
  a_addr_hold: assert property (htrans==2'h2 && !hready |=> htrans==2'h2 && $stable(haddr))
    else $error("address dropped");
  a_no_pipe: assert property (htrans==2'h2 && hready |=> htrans==2'h0)
    else $error("pipelined");
  a_trans_kind: assert property (htrans==2'h0 || htrans==2'h2)
    else $error("bad htrans");
  a_size_legal: assert property (htrans==2'h2 |-> hsize<=3'h2)
    else $error("bad size");
  a_byte_lanes: assert property (htrans==2'h2 && hwrite && hsize==3'h0 && hready
    |=> hwdata=={4{hwdata[7:0]}})
    else $error("byte lanes");
  a_half_lanes: assert property (htrans==2'h2 && hwrite && hsize==3'h1 && hready
    |=> hwdata=={2{hwdata[15:0]}})
    else $error("half lanes");
  a_err_stop: assert property (hresp && hready |=> htrans==2'h0)
    else $error("no stop on error");
endmodule
bind gpdma_top gpdma_props u_props (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hresp(hresp));

// file: gpdma_regs.svh
`ifndef GPDMA_REGS_SVH
`define GPDMA_REGS_SVH

// ==========================================================================
// Global register byte offsets (address bit 8 low).
`define GPDMA_INT_TC_STAT  8'h00
`define GPDMA_INT_TC_CLR   8'h04
`define GPDMA_INT_ERR_STAT 8'h08
`define GPDMA_INT_ERR_CLR  8'h0C
`define GPDMA_RAW_TC       8'h10
`define GPDMA_RAW_ERR      8'h14
`define GPDMA_EN_CH        8'h18
`define GPDMA_GCFG         8'h1C

// ==========================================================================
// Channel register word index (address 0x100 + 0x20 * channel + 4 * index).
`define GPDMA_CH_SRC 3'h0
`define GPDMA_CH_DST 3'h1
`define GPDMA_CH_LLI 3'h2
`define GPDMA_CH_CTL 3'h3
`define GPDMA_CH_CFG 3'h4

// ==========================================================================
// Field positions.
`define GPDMA_CTL_CNT_LO  0
`define GPDMA_CTL_BSZ_LO  12
`define GPDMA_CTL_SW_LO   16
`define GPDMA_CTL_DW_LO   18
`define GPDMA_CTL_SINC    20
`define GPDMA_CTL_DINC    21
`define GPDMA_CTL_TCIE    31
`define GPDMA_CFG_EN      0
`define GPDMA_CFG_SRCP_LO 1
`define GPDMA_CFG_DSTP_LO 6
`define GPDMA_CFG_FLOW_LO 11
`define GPDMA_CFG_EMSK    14
`define GPDMA_CFG_TMSK    15
`define GPDMA_GCFG_EN     0
`define GPDMA_GCFG_BE     1

// ==========================================================================
// Reset values and timing counts.
`define GPDMA_RST_WORD 32'h0000_0000
`define GPDMA_GCFG_RST 2'h0
`define GPDMA_HOLD     3'h3
`define GPDMA_HT_IDLE  2'h0
`define GPDMA_HT_NSEQ  2'h2

`endif

// file: gpdma_top.sv
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
`include "gpdma_regs.svh"
module gpdma_top
  import gpdma_pkg::*;
#(
  parameter int NCH    = 8,
  parameter int NREQ   = 16,
  parameter int NTMR   = 4,
  parameter int FDEPTH = 4
)(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Register port.
  input  wire logic [8:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  // Peripheral and timer requests.
  input  wire logic [NREQ-1:0]  dma_sreq,
  input  wire logic [NREQ-1:0]  dma_breq,
  input  wire logic [NTMR-1:0]  tmr_match,
  output logic      [NREQ-1:0]  dma_done,
  // Bus master.
  output logic      [31:0]      haddr,
  output logic      [1:0]       htrans,
  output logic                  hwrite,
  output logic      [2:0]       hsize,
  output logic      [31:0]      hwdata,
  input  wire logic [31:0]      hrdata,
  input  wire logic             hready,
  input  wire logic             hresp,
  // Interrupts.
  output logic                  irq_tc,
  output logic                  irq_err
);

  // ========================================================================
  // Declarations.
  logic [31:0]     src_reg [NCH];
  logic [31:0]     dst_reg [NCH];
  logic [31:0]     lli_reg [NCH];
  logic [31:0]     ctl_reg [NCH];
  logic [31:0]     cfg_reg [NCH];
  logic [NCH-1:0]  raw_tc_reg;
  logic [NCH-1:0]  raw_err_reg;
  logic [1:0]      gcfg_reg;
  logic [NREQ-1:0] sreq_s1_reg;
  logic [NREQ-1:0] sreq_s2_reg;
  logic [NREQ-1:0] breq_s1_reg;
  logic [NREQ-1:0] breq_s2_reg;
  logic [NTMR-1:0] tmr_s1_reg;
  logic [NTMR-1:0] tmr_s2_reg;
  gpdma_state_t    st_reg;
  logic [2:0]      cur_reg;
  logic [2:0]      beats_reg;
  logic [2:0]      idx_reg;
  logic [1:0]      lli_idx_reg;
  logic [31:0]     req_s;
  logic [31:0]     req_b;
  logic [NCH-1:0]  want;
  logic [NCH-1:0]  burst;
  logic [NCH-1:0]  en_vec;
  logic [NCH-1:0]  tmsk;
  logic [NCH-1:0]  emsk;
  logic [NCH-1:0]  f_empty;
  logic [NCH-1:0]  f_full;
  logic [31:0]     f_head [NCH];
  logic [2:0]      win;
  logic            win_v;
  logic [2:0]      win_blen;
  logic [2:0]      win_n;
  logic [11:0]     win_cnt;
  logic [11:0]     cur_cnt;
  logic [1:0]      sw_c;
  logic [1:0]      dw_c;
  logic [31:0]     src_step;
  logic [31:0]     dst_step;
  logic [31:0]     rd_item;
  logic [31:0]     rd_mux;
  logic            rd_ok;
  logic            wr_ok;
  logic            ll_ok;
  logic            bus_err;
  logic            fin;
  logic            wd_last;
  logic            big_end;
  logic [NCH-1:0]  tc_clr;
  logic [NCH-1:0]  err_clr;

  // ========================================================================
  // Lane handling.
  // Reads pick the addressed lane; byte order within the word follows the
  // endian bit, so a big-endian byte at offset 0 sits in the top lane.
  function automatic logic [31:0] lane_get(input logic [31:0] d, input logic [1:0] a,
                                           input logic [1:0] w, input logic be);
    logic [4:0]  sh;
    logic [31:0] s;
    sh = 5'h00;
    if (w == 2'h0)
      sh = {(be ? ~a : a), 3'h0};
    else if (w == 2'h1)
      sh = {(be ? ~a[1] : a[1]), 4'h0};
    s = d >> sh;
    if (w == 2'h0)
      lane_get = {24'h000000, s[7:0]};
    else if (w == 2'h1)
      lane_get = {16'h0000, s[15:0]};
    else
      lane_get = s;
  endfunction

  // Writes repeat the item on every lane; the slave takes the addressed one.
  function automatic logic [31:0] lane_put(input logic [31:0] d, input logic [1:0] w);
    if (w == 2'h0)
      lane_put = {4{d[7:0]}};
    else if (w == 2'h1)
      lane_put = {2{d[15:0]}};
    else
      lane_put = d;
  endfunction

  // ========================================================================
  // Request synchronisers, two stages on every request and timer input.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sreq_s1_reg <= '0;
      sreq_s2_reg <= '0;
      breq_s1_reg <= '0;
      breq_s2_reg <= '0;
      tmr_s1_reg  <= '0;
      tmr_s2_reg  <= '0;
    end
    else
    begin
      sreq_s1_reg <= dma_sreq;
      sreq_s2_reg <= sreq_s1_reg;
      breq_s1_reg <= dma_breq;
      breq_s2_reg <= breq_s1_reg;
      tmr_s1_reg  <= tmr_match;
      tmr_s2_reg  <= tmr_s1_reg;
    end
  end

  // Selectors 0..15 are peripheral lines, 16..19 timer matches (single only).
  assign req_s = 32'({tmr_s2_reg, sreq_s2_reg});
  assign req_b = 32'(breq_s2_reg);
  assign big_end = gcfg_reg[`GPDMA_GCFG_BE];

  // ========================================================================
  // Per-channel readiness, buffers and registers.
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic [1:0] flow;
    logic [4:0] sel;
    logic       me;
    gpdma_fifo_if #(.W(32)) fif ();

    assign flow = cfg_reg[i][`GPDMA_CFG_FLOW_LO +: 2];
    assign sel = flow[1] ? cfg_reg[i][`GPDMA_CFG_SRCP_LO +: 5] :
                 cfg_reg[i][`GPDMA_CFG_DSTP_LO +: 5];
    assign want[i] = cfg_reg[i][`GPDMA_CFG_EN] && gcfg_reg[`GPDMA_GCFG_EN] &&
                     (flow == FLOW_M2M || req_s[sel] || req_b[sel]);
    assign burst[i] = (flow == FLOW_M2M) || req_b[sel];
    assign en_vec[i] = cfg_reg[i][`GPDMA_CFG_EN];
    assign tmsk[i] = cfg_reg[i][`GPDMA_CFG_TMSK];
    assign emsk[i] = cfg_reg[i][`GPDMA_CFG_EMSK];
    assign me = (cur_reg == 3'(i));

    // One buffer per channel; flushed when the channel aborts.
    assign fif.push  = rd_ok && me;
    assign fif.wdata = rd_item;
    assign fif.pop   = (st_reg == S_WA) && hready && me;
    assign fif.flush = bus_err && me;
    assign f_head[i]  = fif.rdata;
    assign f_empty[i] = fif.empty;
    assign f_full[i]  = fif.full;

    gpdma_fifo #(.W(32), .D(FDEPTH)) u_fifo (
      .clk   (clk),
      .rst_n (rst_n),
      .f     (fif)
    );

    // Software writes first; engine updates of the active channel override.
    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        src_reg[i] <= `GPDMA_RST_WORD;
        dst_reg[i] <= `GPDMA_RST_WORD;
        lli_reg[i] <= `GPDMA_RST_WORD;
        ctl_reg[i] <= `GPDMA_RST_WORD;
        cfg_reg[i] <= `GPDMA_RST_WORD;
      end
      else
      begin
        if (reg_wr && reg_addr[8] && reg_addr[7:5] == 3'(i))
        begin
          case (reg_addr[4:2])
            `GPDMA_CH_SRC: src_reg[i] <= reg_wdata;
            `GPDMA_CH_DST: dst_reg[i] <= reg_wdata;
            `GPDMA_CH_LLI: lli_reg[i] <= reg_wdata;
            `GPDMA_CH_CTL: ctl_reg[i] <= reg_wdata;
            `GPDMA_CH_CFG: cfg_reg[i] <= reg_wdata;
            default: ;
          endcase
        end
        if (me && rd_ok)
          src_reg[i] <= src_reg[i] + src_step;
        if (me && wr_ok)
        begin
          dst_reg[i] <= dst_reg[i] + dst_step;
          ctl_reg[i][`GPDMA_CTL_CNT_LO +: 12] <= cur_cnt - 12'h001;
        end
        if (me && ll_ok)
        begin
          case (lli_idx_reg)
            2'h0: src_reg[i] <= hrdata;
            2'h1: dst_reg[i] <= hrdata;
            2'h2: lli_reg[i] <= hrdata;
            default: ctl_reg[i] <= hrdata;
          endcase
        end
        if (me && (bus_err || fin))
          cfg_reg[i][`GPDMA_CFG_EN] <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Arbitration and burst sizing.
  // Scanning downward leaves the lowest ready channel as the winner.
  always_comb
  begin
    win   = 3'h0;
    win_v = 1'b0;
    for (int k = NCH - 1; k >= 0; k--)
    begin
      if (want[k])
      begin
        win   = 3'(k);
        win_v = 1'b1;
      end
    end
  end

  // Burst codes 0,1,2 give 1,2,4 items; larger codes are held to the buffer.
  assign win_cnt  = ctl_reg[win][`GPDMA_CTL_CNT_LO +: 12];
  assign win_blen = (ctl_reg[win][`GPDMA_CTL_BSZ_LO +: 2] >= 2'h2) ? 3'(FDEPTH) :
                    3'h1 << ctl_reg[win][`GPDMA_CTL_BSZ_LO +: 2];
  assign win_n    = !burst[win] ? 3'h1 :
                    (win_cnt < 12'(win_blen)) ? win_cnt[2:0] : win_blen;

  // Widths and steps of the active channel; code 3 acts as a word.
  assign cur_cnt  = ctl_reg[cur_reg][`GPDMA_CTL_CNT_LO +: 12];
  assign sw_c     = (ctl_reg[cur_reg][`GPDMA_CTL_SW_LO +: 2] == 2'h3) ? 2'h2 :
                    ctl_reg[cur_reg][`GPDMA_CTL_SW_LO +: 2];
  assign dw_c     = (ctl_reg[cur_reg][`GPDMA_CTL_DW_LO +: 2] == 2'h3) ? 2'h2 :
                    ctl_reg[cur_reg][`GPDMA_CTL_DW_LO +: 2];
  assign src_step = ctl_reg[cur_reg][`GPDMA_CTL_SINC] ? (32'h1 << sw_c) : 32'h0;
  assign dst_step = ctl_reg[cur_reg][`GPDMA_CTL_DINC] ? (32'h1 << dw_c) : 32'h0;
  assign rd_item  = lane_get(hrdata, haddr[1:0], sw_c, big_end);

  // ========================================================================
  // Bus phase strobes.
  assign rd_ok   = (st_reg == S_RD) && hready && !hresp;
  assign wr_ok   = (st_reg == S_WD) && hready && !hresp;
  assign ll_ok   = (st_reg == S_LD) && hready && !hresp;
  assign bus_err = (st_reg == S_RD || st_reg == S_WD || st_reg == S_LD) && hresp;
  assign wd_last = wr_ok && (idx_reg + 3'h1 == beats_reg);
  assign fin     = (st_reg == S_CHK) && (idx_reg == `GPDMA_HOLD) &&
                   (cur_cnt == 12'h000) && (lli_reg[cur_reg] == 32'h0);

  // ========================================================================
  // Transfer engine: one item per address and data phase, no pipelining.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg      <= S_IDLE;
      cur_reg     <= 3'h0;
      beats_reg   <= 3'h0;
      idx_reg     <= 3'h0;
      lli_idx_reg <= 2'h0;
      haddr       <= 32'h0;
      htrans      <= `GPDMA_HT_IDLE;
      hwrite      <= 1'b0;
      hsize       <= 3'h0;
      hwdata      <= 32'h0;
    end
    else if (bus_err)
    begin
      st_reg <= S_IDLE;
      htrans <= `GPDMA_HT_IDLE;
      hwrite <= 1'b0;
    end
    else
    begin
      unique case (st_reg)
        S_IDLE:
          if (win_v)
          begin
            cur_reg   <= win;
            beats_reg <= win_n;
            idx_reg   <= 3'h0;
            if (win_cnt == 12'h000)
              st_reg <= S_CHK;
            else
            begin
              st_reg <= S_RA;
              haddr  <= src_reg[win];
              hsize  <= {1'b0, (ctl_reg[win][`GPDMA_CTL_SW_LO +: 2] == 2'h3) ? 2'h2 :
                                ctl_reg[win][`GPDMA_CTL_SW_LO +: 2]};
              hwrite <= 1'b0;
              htrans <= `GPDMA_HT_NSEQ;
            end
          end
        S_RA:
          if (hready && !f_full[cur_reg])
          begin
            htrans <= `GPDMA_HT_IDLE;
            st_reg <= S_RD;
          end
        S_RD:
          if (hready)
          begin
            htrans <= `GPDMA_HT_NSEQ;
            if (idx_reg + 3'h1 == beats_reg)
            begin
              idx_reg <= 3'h0;
              st_reg  <= S_WA;
              haddr   <= dst_reg[cur_reg];
              hsize   <= {1'b0, dw_c};
              hwrite  <= 1'b1;
            end
            else
            begin
              idx_reg <= idx_reg + 3'h1;
              st_reg  <= S_RA;
              haddr   <= haddr + src_step;
            end
          end
        S_WA:
          if (hready && !f_empty[cur_reg])
          begin
            htrans <= `GPDMA_HT_IDLE;
            hwdata <= lane_put(f_head[cur_reg], dw_c);
            st_reg <= S_WD;
          end
        S_WD:
          if (hready)
          begin
            if (idx_reg + 3'h1 == beats_reg)
            begin
              idx_reg <= 3'h0;
              hwrite  <= 1'b0;
              st_reg  <= S_CHK;
            end
            else
            begin
              idx_reg <= idx_reg + 3'h1;
              htrans  <= `GPDMA_HT_NSEQ;
              haddr   <= haddr + dst_step;
              st_reg  <= S_WA;
            end
          end
        // The hold lets a served peripheral drop its request through the
        // synchroniser before the next arbitration.
        S_CHK:
        begin
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == `GPDMA_HOLD)
          begin
            idx_reg <= 3'h0;
            if (cur_cnt == 12'h000 && lli_reg[cur_reg] != 32'h0)
            begin
              lli_idx_reg <= 2'h0;
              haddr       <= lli_reg[cur_reg];
              hsize       <= 3'h2;
              hwrite      <= 1'b0;
              htrans      <= `GPDMA_HT_NSEQ;
              st_reg      <= S_LA;
            end
            else
              st_reg <= S_IDLE;
          end
        end
        S_LA:
          if (hready)
          begin
            htrans <= `GPDMA_HT_IDLE;
            st_reg <= S_LD;
          end
        S_LD:
          if (hready)
          begin
            if (lli_idx_reg == 2'h3)
              st_reg <= S_IDLE;
            else
            begin
              lli_idx_reg <= lli_idx_reg + 2'h1;
              haddr       <= haddr + 32'h4;
              htrans      <= `GPDMA_HT_NSEQ;
              st_reg      <= S_LA;
            end
          end
        default:
        begin
          st_reg <= S_IDLE;
          htrans <= `GPDMA_HT_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Status, interrupts and peripheral completion.
  assign tc_clr  = (reg_wr && reg_addr == {1'b0, `GPDMA_INT_TC_CLR}) ? reg_wdata[NCH-1:0] : '0;
  assign err_clr = (reg_wr && reg_addr == {1'b0, `GPDMA_INT_ERR_CLR}) ? reg_wdata[NCH-1:0] : '0;

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      raw_tc_reg  <= '0;
      raw_err_reg <= '0;
      gcfg_reg    <= `GPDMA_GCFG_RST;
      irq_tc      <= 1'b0;
      irq_err     <= 1'b0;
    end
    else
    begin
      raw_tc_reg  <= (raw_tc_reg & ~tc_clr) |
                     ((fin && ctl_reg[cur_reg][`GPDMA_CTL_TCIE]) ? NCH'(1) << cur_reg : '0);
      raw_err_reg <= (raw_err_reg & ~err_clr) | (bus_err ? NCH'(1) << cur_reg : '0);
      irq_tc      <= |(raw_tc_reg & tmsk);
      irq_err     <= |(raw_err_reg & emsk);
      if (reg_wr && reg_addr == {1'b0, `GPDMA_GCFG})
        gcfg_reg <= reg_wdata[1:0];
    end
  end

  // Pulses the served peripheral lines as the last write of a burst ends.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dma_done <= '0;
    else
      dma_done <= wd_last ?
        NREQ'((g_flow_src() ? (32'h1 << cfg_reg[cur_reg][`GPDMA_CFG_SRCP_LO +: 5]) : 32'h0) |
              (g_flow_dst() ? (32'h1 << cfg_reg[cur_reg][`GPDMA_CFG_DSTP_LO +: 5]) : 32'h0)) :
        '0;
  end

  function automatic logic g_flow_src();
    g_flow_src = cfg_reg[cur_reg][`GPDMA_CFG_FLOW_LO + 1];
  endfunction

  function automatic logic g_flow_dst();
    g_flow_dst = cfg_reg[cur_reg][`GPDMA_CFG_FLOW_LO];
  endfunction

  // ========================================================================
  // Register read port.
  always_comb
  begin
    rd_mux = 32'h0;
    if (reg_addr[8])
    begin
      case (reg_addr[4:2])
        `GPDMA_CH_SRC: rd_mux = src_reg[reg_addr[7:5]];
        `GPDMA_CH_DST: rd_mux = dst_reg[reg_addr[7:5]];
        `GPDMA_CH_LLI: rd_mux = lli_reg[reg_addr[7:5]];
        `GPDMA_CH_CTL: rd_mux = ctl_reg[reg_addr[7:5]];
        `GPDMA_CH_CFG: rd_mux = cfg_reg[reg_addr[7:5]];
        default:       rd_mux = 32'h0;
      endcase
    end
    else
    begin
      case (reg_addr[7:0])
        `GPDMA_INT_TC_STAT:  rd_mux = 32'(raw_tc_reg & tmsk);
        `GPDMA_INT_ERR_STAT: rd_mux = 32'(raw_err_reg & emsk);
        `GPDMA_RAW_TC:       rd_mux = 32'(raw_tc_reg);
        `GPDMA_RAW_ERR:      rd_mux = 32'(raw_err_reg);
        `GPDMA_EN_CH:        rd_mux = 32'(en_vec);
        `GPDMA_GCFG:         rd_mux = 32'(gcfg_reg);
        default:             rd_mux = 32'h0;
      endcase
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end
endmodule

// file: gpdma_top_tb.sv
`timescale 1ns/1ns
// ====
// Bench: register tasks drive the controller, a bus memory answers.
module gpdma_top_tb;
  logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, slow = 0;
  logic [8:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, haddr, hwdata, hrdata;
  logic [15:0] dma_breq = 0, dma_done;
  logic [3:0]  tmr_match = 0;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwrite, hready, hresp, irq_tc, irq_err;
  int          mismatches = 0, compares = 0, cyc = 0, n;
  gpdma_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_sreq(16'h0000),
    .dma_breq(dma_breq), .tmr_match(tmr_match), .dma_done(dma_done), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
    .hready(hready), .hresp(hresp), .irq_tc(irq_tc), .irq_err(irq_err));
  gpdma_mem_model ram (.clk(clk), .rst_n(rst_n), .slow(slow), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hrdata(hrdata), .hready(hready), .hresp(hresp));
  // Compares and tasks.
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rw(input bit w, input logic [8:0] ad, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
    if (!w)
      cmp(reg_rdata, d);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Clock and hang guard.
  initial
    forever #50 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      close_out;
    end
  end
  // Test sequence.
  initial
  begin
    for (int i = 0; i < 64; i++)
      ram.mem[i] = 32'hA5A5_0000 + i;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rw(0, 9'h01C, 32'h0);
    rw(1, 9'h020, 32'hFFFF_FFFF);
    rw(0, 9'h020, 32'h0);
    rw(1, 9'h10C, 32'h803A_2004);
    rw(1, 9'h104, 32'h80);
    rw(1, 9'h110, 32'hC001);
    rw(1, 9'h01C, 32'h1);
    rw(0, 9'h10C, 32'h803A_2004);
    for (n = 0; n < 300 && irq_tc !== 1'b1; n++) @(posedge clk);
    cmp(irq_tc, 32'h1);
    for (int k = 0; k < 4; k++) cmp(ram.mem[32+k], 32'hA5A5_0000 + k);
    rw(0, 9'h010, 32'h1);
    rw(1, 9'h004, 32'h1);
    rw(0, 9'h018, 32'h0);
    $display("copy test done");
    rw(1, 9'h120, 32'hE000_0000);
    rw(1, 9'h12C, 32'h803A_2001);
    rw(1, 9'h130, 32'hC001);
    for (n = 0; n < 300 && irq_err !== 1'b1; n++) @(posedge clk);
    cmp(irq_err, 32'h1);
    rw(0, 9'h014, 32'h2);
    rw(0, 9'h018, 32'h0);
    $display("error test done");
    slow <= 1'b1;
    rw(1, 9'h140, 32'h40);
    rw(1, 9'h144, 32'hC0);
    rw(1, 9'h14C, 32'h8020_1002);
    rw(1, 9'h150, 32'hD007);
    rw(0, 9'h010, 32'h0);
    cmp(ram.mem[48], 32'hA5A5_0030);
    dma_breq <= 16'h0008;
    for (n = 0; n < 300 && dma_done[3] !== 1'b1; n++) @(posedge clk);
    cmp(dma_done[3], 32'h1);
    dma_breq <= 16'h0000;
    repeat (4) @(posedge clk);
    rw(0, 9'h010, 32'h4);
    cmp(ram.mem[48], 32'hA5A5_1010);
    $display("burst test done");
    rw(1, 9'h160, 32'h44);
    rw(1, 9'h164, 32'hD0);
    rw(1, 9'h16C, 32'h803A_1002);
    rw(1, 9'h170, 32'hD021);
    tmr_match <= 4'h1;
    repeat (4) @(posedge clk);
    tmr_match <= 4'h0;
    repeat (20) @(posedge clk);
    cmp(ram.mem[52], 32'hA5A5_0011);
    cmp(ram.mem[53], 32'hA5A5_0035);
    rw(0, 9'h16C, 32'h803A_1001);
    $display("timer test done");
    close_out;
  end
endmodule
